/* File: core/asr_pkg.sv */
package asr_pkg;

    // ****************************************************
    // Timing
    // ****************************************************
    localparam int unsigned WORD_BITS = 16;
    localparam int unsigned CLK_PERIOD_NS = 40;
    // Host-made link clock period; 12 cycles per half outlast both samplers and the shift
    localparam int unsigned LINK_PERIOD_NS = 960;
    localparam int unsigned SCLK_HALF_CYCLES = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    // Modelled conversion time of the core
    localparam int unsigned CONV_TIME_NS = 1600;
    localparam int unsigned CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Width of the convert start low pulse
    localparam int unsigned START_LOW_CYCLES = 4;
    // Overrun pulse length, long enough for a three-flop reader to agree
    localparam int unsigned OVR_PULSE_CYCLES = 3;

    // ****************************************************
    // Controller register map
    // ****************************************************
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_MASK = 5'h08;
    localparam logic [4:0] OFS_DATA = 5'h0C;
    localparam logic [4:0] OFS_CFG = 5'h10;
    localparam int unsigned CTRL_GO = 0;
    localparam int unsigned STAT_DONE = 0;
    localparam int unsigned STAT_OVR = 1;
    localparam int unsigned CFG_DURING = 0;
    localparam int unsigned CFG_CHAIN_LVL = 1;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [1:0] CFG_RST = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Controller sequence
    typedef enum logic [2:0] {
        HS_IDLE,
        HS_START,
        HS_WAIT_HI,
        HS_WAIT_LO,
        HS_SHIFT
    } asr_host_state_t;

endpackage

/* File: core/asr_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Serial link between the converter and its controller
interface asr_link_if;
    logic sclk; // Serial clock, made by the controller
    logic cs_n; // Chip select
    logic rd_n; // Read enable
    logic convert_start_n; // Shared convert start
    logic chain_data_in; // Chain input, held fixed when unused
    logic busy; // Conversion running
    logic serial_data_out; // Data bit driven by converter
    logic serial_data_out_oe_n; // Low while converter drives
    logic read_overrun_flag; // Incomplete read pulse
    wire logic sdo_line; // Resolved data wire

    // Released line shows the inverse, so a sample taken too early shows up
    assign sdo_line = serial_data_out_oe_n ? !serial_data_out : serial_data_out;

    modport dev (
        input sclk, cs_n, rd_n, convert_start_n, chain_data_in,
        output busy, serial_data_out, serial_data_out_oe_n, read_overrun_flag
    );
    modport host (
        output sclk, cs_n, rd_n, convert_start_n, chain_data_in,
        input busy, sdo_line, read_overrun_flag
    );
endinterface
`default_nettype wire

/* File: core/asr_dev.sv */
`timescale 1ns/10ps
`default_nettype none
// Converter end: conversion timer and slave serial readout
module asr_dev
    import asr_pkg::*;
#(
    parameter int unsigned NBITS = WORD_BITS,
    parameter int unsigned CONV_LEN = CONV_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    asr_link_if.dev link,
    input wire logic clock_source_select,
    input wire logic interface_select,
    input wire logic read_during_mode,
    input wire logic [NBITS-1:0] sample_data,
    output logic conv_done
);

    initial begin
        if (NBITS < 2 || NBITS > 32 || CONV_LEN < 2) begin
            $error("asr_dev: unsupported parameters");
        end
    end

    // ****************************************************
    // Pin synchronisers
    // ****************************************************
    logic [2:0] sclk_sy; // Three-stage sampler of serial clock
    logic [2:0] cs_sy; // Chip select sampler
    logic [2:0] rd_sy; // Read enable sampler
    logic [2:0] cnv_sy; // Convert start sampler
    logic [2:0] chn_sy; // Chain input sampler
    logic sclk_lvl; // Filtered serial clock
    logic cs_lvl; // Filtered chip select, active low
    logic rd_lvl; // Filtered read enable, active low
    logic cnv_lvl; // Filtered convert start, active low
    logic chn_lvl; // Filtered chain input

    // Sample all link pins; stage 1 feeds only stage 2
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_sy <= 3'h0;
            cs_sy <= 3'h7;
            rd_sy <= 3'h7;
            cnv_sy <= 3'h7;
            chn_sy <= 3'h0;
        end else begin
            sclk_sy <= {sclk_sy[1:0], link.sclk};
            cs_sy <= {cs_sy[1:0], link.cs_n};
            rd_sy <= {rd_sy[1:0], link.rd_n};
            cnv_sy <= {cnv_sy[1:0], link.convert_start_n};
            chn_sy <= {chn_sy[1:0], link.chain_data_in};
        end
    end

    // A level moves only once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_lvl <= 1'b0;
            cs_lvl <= 1'b1;
            rd_lvl <= 1'b1;
            cnv_lvl <= 1'b1;
            chn_lvl <= 1'b0;
        end else begin
            if (sclk_sy[1] == sclk_sy[2]) sclk_lvl <= sclk_sy[2];
            if (cs_sy[1] == cs_sy[2]) cs_lvl <= cs_sy[2];
            if (rd_sy[1] == rd_sy[2]) rd_lvl <= rd_sy[2];
            if (cnv_sy[1] == cnv_sy[2]) cnv_lvl <= cnv_sy[2];
            if (chn_sy[1] == chn_sy[2]) chn_lvl <= chn_sy[2];
        end
    end

    // ****************************************************
    // Port qualification and clock edges
    // ****************************************************
    logic port_on; // Slave serial port is the active one
    logic clk_gate; // Serial clock is listened to
    logic out_en; // Data may be driven
    logic sclk_new; // Agreed new clock level
    logic sclk_chg; // Agreed clock level differs from held one
    logic sclk_rise; // Rising serial clock edge
    logic sclk_fall; // Falling serial clock edge
    logic cnv_fall; // Convert start asserted

    // Master-clock mode is not served, so external clock only
    assign port_on = interface_select && clock_source_select;
    assign clk_gate = port_on && !cs_lvl;
    assign out_en = clk_gate && !rd_lvl;
    assign sclk_new = sclk_sy[2];
    assign sclk_chg = (sclk_sy[1] == sclk_sy[2]) && (sclk_new != sclk_lvl);
    // Edges from a sampled level: free or gated clock, any idle level
    assign sclk_rise = clk_gate && sclk_chg && sclk_new;
    assign sclk_fall = clk_gate && sclk_chg && !sclk_new;
    assign cnv_fall = (cnv_sy[1] == cnv_sy[2]) && !cnv_sy[2] && cnv_lvl;

    // ****************************************************
    // Conversion timer
    // ****************************************************
    logic [$clog2(CONV_LEN+1)-1:0] conv_cnt; // Cycles left in conversion
    logic conv_end; // Last cycle of a conversion

    assign conv_end = link.busy && (conv_cnt == 1);

    // Start on convert request; a running conversion cannot restart
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link.busy <= 1'b0;
            conv_cnt <= '0;
        end else if (conv_end) begin
            link.busy <= 1'b0;
            conv_cnt <= '0;
        end else if (link.busy) begin
            conv_cnt <= conv_cnt - 1'b1;
        end else if (cnv_fall) begin
            link.busy <= 1'b1;
            conv_cnt <= ($clog2(CONV_LEN+1))'(CONV_LEN);
        end
    end

    // One-cycle notice to the core user
    always_ff @(posedge aclk) begin
        if (!aresetn) conv_done <= 1'b0;
        else conv_done <= conv_end;
    end

    // ****************************************************
    // Output shift register
    // ****************************************************
    logic [NBITS-1:0] shreg; // Result being shifted out
    logic chain_hold; // Chain bit caught on the opposite edge
    logic first_edge; // Next rising edge presents the MSB only
    logic [5:0] bits_out; // Bits sampled by the reader

    // Chain input caught on the falling edge, output moves on rising
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chain_hold <= 1'b0;
        end else if (sclk_fall) begin
            // No chaining while reading during conversion
            chain_hold <= read_during_mode ? 1'b0 : chn_lvl;
        end
    end

    // New result loaded at conversion end, then shifted on rising edges until the next end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shreg <= '0;
            first_edge <= 1'b1;
        end else if (conv_end) begin
            shreg <= sample_data;
            first_edge <= 1'b1;
        end else if (!clk_gate) begin
            // Deselect restarts the frame at the present bit
            first_edge <= 1'b1;
        end else if (sclk_rise) begin
            first_edge <= 1'b0;
            // Leading edge of a frame keeps the MSB on the pin
            if (!first_edge) begin
                shreg <= {shreg[NBITS-2:0], chain_hold};
            end
        end
    end

    // Count bits taken by the reader since the last load
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bits_out <= '0;
        end else if (conv_end) begin
            bits_out <= '0;
        end else if (sclk_fall && bits_out != 6'h3F) begin
            bits_out <= bits_out + 6'h01;
        end
    end

    // ****************************************************
    // Pin drivers
    // ****************************************************
    // Registered data and enable; bit changes on a rising edge or when a conversion end loads a new result
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link.serial_data_out <= 1'b0;
            link.serial_data_out_oe_n <= 1'b1;
        end else begin
            link.serial_data_out <= shreg[NBITS-1];
            link.serial_data_out_oe_n <= !out_en;
        end
    end

    logic [1:0] ovr_hold; // Cycles the overrun pulse still stands

    // Overrun only matters when the old word is read during conversion;
    // stretched so a reader that waits for two samples to agree still sees it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link.read_overrun_flag <= 1'b0;
            ovr_hold <= 2'h0;
        end else if (conv_end && read_during_mode && port_on && (bits_out < 6'(NBITS))) begin
            link.read_overrun_flag <= 1'b1;
            ovr_hold <= 2'(OVR_PULSE_CYCLES - 1);
        end else if (ovr_hold != 2'h0) begin
            ovr_hold <= ovr_hold - 2'h1;
        end else begin
            link.read_overrun_flag <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* File: core/asr_host.sv */
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Controller end: AXI4-Lite registers driving the serial readout
module asr_host
    import asr_pkg::*;
#(
    parameter int unsigned NBITS = WORD_BITS,
    parameter int unsigned HALF = SCLK_HALF_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    asr_link_if.host link,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);

    initial begin
        if (NBITS < 1 || NBITS > 32 || HALF < 4 || HALF > 255) begin
            $error("asr_host: unsupported parameters");
        end
    end

    // ****************************************************
    // Register bus
    // ****************************************************
    logic wr_go; // Write accepted this cycle
    logic [1:0] cfg; // Read mode and chain input level
    logic [1:0] mask; // Interrupt mask
    logic [1:0] status; // Sticky done and overrun
    logic [31:0] rx; // Received bits, newest in bit 0
    logic go_req; // Start request from software
    logic ev_done; // Read finished
    logic ev_ovr; // Overrun seen

    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;

    // Take address and data together, answer one cycle later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (s_axi_awaddr > OFS_CFG) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Configuration and mask stores, byte lane 0 only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg <= CFG_RST;
            mask <= MASK_RST;
        end else if (wr_go && s_axi_wstrb[0]) begin
            if (s_axi_awaddr == OFS_CFG) cfg <= s_axi_wdata[1:0];
            if (s_axi_awaddr == OFS_MASK) mask <= s_axi_wdata[1:0];
        end
    end

    // Writing a one to go requests a conversion and read
    always_ff @(posedge aclk) begin
        if (!aresetn) go_req <= 1'b0;
        else go_req <= wr_go && s_axi_wstrb[0] && (s_axi_awaddr == OFS_CTRL)
            && s_axi_wdata[CTRL_GO];
    end

    // Sticky events: a new event wins over a write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= 2'h0;
        end else begin
            if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == OFS_STATUS) begin
                status <= (status & ~s_axi_wdata[1:0]) | {ev_ovr, ev_done};
            end else begin
                status <= status | {ev_ovr, ev_done};
            end
        end
    end

    // Level interrupt from unmasked status
    always_ff @(posedge aclk) begin
        if (!aresetn) irq <= 1'b0;
        else irq <= |(status & mask);
    end

    // Single read channel, one cycle to answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr)
                OFS_STATUS: s_axi_rdata <= {30'h0, status};
                OFS_MASK: s_axi_rdata <= {30'h0, mask};
                OFS_DATA: s_axi_rdata <= rx;
                OFS_CFG: s_axi_rdata <= {30'h0, cfg};
                OFS_CTRL: s_axi_rdata <= 32'h0;
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rready) s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************
    // Link input samplers
    // ****************************************************
    logic [2:0] busy_sy; // Busy sampler
    logic [2:0] ovr_sy; // Overrun sampler
    logic [2:0] sdo_sy; // Data sampler
    logic busy_lvl; // Agreed busy
    logic ovr_lvl; // Agreed overrun
    logic sdo_lvl; // Agreed data bit

    // Stage 1 feeds only stage 2
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_sy <= 3'h0;
            ovr_sy <= 3'h0;
            sdo_sy <= 3'h0;
            busy_lvl <= 1'b0;
            ovr_lvl <= 1'b0;
            sdo_lvl <= 1'b0;
        end else begin
            busy_sy <= {busy_sy[1:0], link.busy};
            ovr_sy <= {ovr_sy[1:0], link.read_overrun_flag};
            sdo_sy <= {sdo_sy[1:0], link.sdo_line};
            if (busy_sy[1] == busy_sy[2]) busy_lvl <= busy_sy[2];
            if (ovr_sy[1] == ovr_sy[2]) ovr_lvl <= ovr_sy[2];
            if (sdo_sy[1] == sdo_sy[2]) sdo_lvl <= sdo_sy[2];
        end
    end

    assign ev_ovr = (ovr_sy[1] == ovr_sy[2]) && ovr_sy[2] && !ovr_lvl;

    // ****************************************************
    // Readout sequence
    // ****************************************************
    asr_host_state_t state; // Sequence state
    logic [7:0] tick; // Cycles within a phase
    logic [5:0] nbit; // Bits received in this frame

    assign ev_done = (state == HS_SHIFT) && link.sclk && (tick == 8'(HALF - 1))
        && (nbit == 6'(NBITS - 1));

    // Convert, wait for busy, then clock in one word with mode 0/1 timing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= HS_IDLE;
            tick <= 8'h0;
            nbit <= 6'h0;
            rx <= 32'h0;
            link.sclk <= 1'b0;
            link.cs_n <= 1'b1;
            link.rd_n <= 1'b1;
            link.convert_start_n <= 1'b1;
            link.chain_data_in <= 1'b0;
        end else begin
            // Fixed chain level when no upstream stage exists
            link.chain_data_in <= cfg[CFG_CHAIN_LVL];
            case (state)
                HS_IDLE: begin
                    if (go_req) begin
                        link.convert_start_n <= 1'b0;
                        tick <= 8'h0;
                        state <= HS_START;
                    end
                end
                HS_START: begin
                    tick <= tick + 8'h01;
                    if (tick == 8'(START_LOW_CYCLES - 1)) begin
                        link.convert_start_n <= 1'b1;
                        state <= HS_WAIT_HI;
                    end
                end
                HS_WAIT_HI: begin
                    if (busy_lvl) begin
                        // Read-during mode takes the old word now
                        state <= cfg[CFG_DURING] ? HS_SHIFT : HS_WAIT_LO;
                        tick <= 8'h0;
                        nbit <= 6'h0;
                        link.cs_n <= !cfg[CFG_DURING];
                        link.rd_n <= !cfg[CFG_DURING];
                    end
                end
                HS_WAIT_LO: begin
                    // Clock only after busy falls, keeping conversion quiet
                    if (!busy_lvl) begin
                        link.cs_n <= 1'b0;
                        link.rd_n <= 1'b0;
                        tick <= 8'h0;
                        state <= HS_SHIFT;
                    end
                end
                HS_SHIFT: begin
                    // Idle low clock; sample on the falling edge
                    tick <= tick + 8'h01;
                    if (tick == 8'(HALF - 1)) begin
                        tick <= 8'h0;
                        link.sclk <= !link.sclk;
                        if (link.sclk) begin
                            rx <= {rx[30:0], sdo_lvl};
                            nbit <= nbit + 6'h01;
                            if (nbit == 6'(NBITS - 1)) begin
                                link.cs_n <= 1'b1;
                                link.rd_n <= 1'b1;
                                state <= HS_IDLE;
                            end
                        end
                    end
                end
                default: state <= HS_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

/* File: dv/asr_props.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// Link checker
// ****
module asr_props #(
    parameter int unsigned CONV_LEN = 40
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic convert_start_n,
    input wire logic busy,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe_n,
    input wire logic read_overrun_flag
);
    logic [9:0] busy_cnt; // Busy cycles so far
    // Counts busy length; cleared while idle
    always_ff @(posedge aclk) begin
        if (!aresetn || !busy) begin
            busy_cnt <= 10'h000;
        end else begin
            busy_cnt <= busy_cnt + 10'h001;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Pin sampler and output register lag 5 cycles, so 6 is just enough
    chk_cs_release: assert property (cs_n [*6] |-> serial_data_out_oe_n)
        else $error("data driven while deselected");
    chk_rd_release: assert property (rd_n [*6] |-> serial_data_out_oe_n)
        else $error("data driven while read high");
    chk_oe_select: assert property ($fell(serial_data_out_oe_n) |-> !cs_n && !rd_n)
        else $error("driver enabled without select");
    chk_busy_start: assert property ($fell(convert_start_n) && !busy |-> ##[1:6] busy)
        else $error("convert start not taken");
    chk_busy_len: assert property ($fell(busy) |-> busy_cnt >= CONV_LEN - 1
        && busy_cnt <= CONV_LEN + 1)
        else $error("conversion length wrong");
    // Bit moves after a rise, so it must hold past the fall
    chk_bit_stable: assert property ($fell(sclk) && !serial_data_out_oe_n && !busy
        |-> ##1 $stable(serial_data_out) [*6])
        else $error("data bit moved near falling clock");
    // Pulse stands three cycles so the reader's sampler can agree on it
    chk_ovr_pulse: assert property ($rose(read_overrun_flag) |-> read_overrun_flag [*3]
        ##1 !read_overrun_flag)
        else $error("overrun pulse length wrong");
    chk_ovr_at_end: assert property ($rose(read_overrun_flag) |-> !busy && $past(busy))
        else $error("overrun flag away from conversion end");
    cov_overrun: cover property (read_overrun_flag);
    cov_read: cover property ($fell(serial_data_out_oe_n));
    cov_conv: cover property ($fell(busy));
endmodule
`default_nettype wire

/* File: dv/adc_slave_serial_readout_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module adc_slave_serial_readout_tb_top
    import asr_pkg::*;
;
    // ****
    // Bench signals
    // ****
    // Long enough that a read during busy ends in its first half
    localparam int unsigned DEV_CONV = 900;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic clock_source_select = 1'b1; // External clock strap
    logic interface_select = 1'b1; // Serial port strap
    logic read_during_mode = 1'b0;
    logic [15:0] sample_data = 16'hA5C3;
    logic conv_done;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_word;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    int error_cnt = 0;
    int tests_run = 0;
    // Free-running system clock
    always #(CLK_PERIOD_NS / 2) aclk = ~aclk;
    asr_link_if asr_link_if_inst ();
    asr_dev #(.CONV_LEN(DEV_CONV)) asr_dev_inst (.aclk, .aresetn, .link(asr_link_if_inst),
        .clock_source_select, .interface_select, .read_during_mode, .sample_data, .conv_done);
    asr_host asr_host_inst (.aclk, .aresetn, .link(asr_link_if_inst), .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .irq);
    asr_props #(.CONV_LEN(DEV_CONV)) asr_props_inst (.aclk, .aresetn,
        .sclk(asr_link_if_inst.sclk), .cs_n(asr_link_if_inst.cs_n),
        .rd_n(asr_link_if_inst.rd_n), .convert_start_n(asr_link_if_inst.convert_start_n),
        .busy(asr_link_if_inst.busy), .serial_data_out(asr_link_if_inst.serial_data_out),
        .serial_data_out_oe_n(asr_link_if_inst.serial_data_out_oe_n),
        .read_overrun_flag(asr_link_if_inst.read_overrun_flag));
    // ****
    // Shared tasks
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // One write; each valid drops at its own ready, bready stands until bvalid
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [4:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        rd_word = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Bounded wait for the interrupt line
    task automatic wait_irq();
        for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_regs();
        axi_rd(OFS_CFG);
        chk(rd_word, {30'h0, CFG_RST});
        axi_rd(5'h14);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        axi_wr(5'h14, 32'h1);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    endtask
    // Read after conversion, done raises the interrupt
    task automatic t_after();
        axi_wr(OFS_MASK, 32'h1);
        axi_wr(OFS_CTRL, 32'h1);
        wait_irq();
        axi_rd(OFS_DATA);
        chk(rd_word, 32'h0000A5C3);
        axi_wr(OFS_STATUS, 32'h1);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
    endtask
    // Read during conversion; first pass only refills the word
    task automatic t_during(input logic [15:0] nxt, input logic [15:0] exp, input logic use_exp);
        sample_data <= nxt;
        read_during_mode <= 1'b1;
        axi_wr(OFS_CFG, 32'h1);
        axi_wr(OFS_CTRL, 32'h1);
        wait_irq();
        while (asr_link_if_inst.busy !== 1'b0) @(posedge aclk);
        chk({31'h0, conv_done}, 32'h1);
        repeat (4) @(posedge aclk);
        axi_rd(OFS_STATUS);
        chk(rd_word, 32'h1);
        axi_rd(OFS_DATA);
        if (use_exp) begin
            chk({16'h0, rd_word[15:0]}, {16'h0, exp});
        end
        axi_wr(OFS_STATUS, 32'h3);
    endtask
    // Clock source pulled mid-read so bits go missing
    task automatic t_ovr();
        axi_wr(OFS_MASK, 32'h2);
        axi_wr(OFS_CTRL, 32'h1);
        while (asr_link_if_inst.busy !== 1'b1) @(posedge aclk);
        repeat (40) @(posedge aclk);
        clock_source_select <= 1'b0;
        repeat (100) @(posedge aclk);
        clock_source_select <= 1'b1;
        wait_irq();
        axi_rd(OFS_STATUS);
        chk({31'h0, rd_word[1]}, 32'h1);
        axi_wr(OFS_STATUS, 32'h2);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
    endtask
    task automatic results();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (5) @(posedge aclk);
        t_regs();
        t_after();
        t_during(16'h3C5A, 16'h0000, 1'b0);
        t_during(16'h0FF0, 16'h3C5A, 1'b1);
        t_ovr();
        results();
    end
    // Watchdog against a hung handshake
    initial begin
        #(CLK_PERIOD_NS * 20000);
        error_cnt++;
        results();
    end
endmodule
`default_nettype wire
